// ### design/dsa_pkg.sv
package dsa_pkg;

  // ---------------------------------------------------------------------------
  // Timing at the 100 MHz system clock
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Plain defaults; the electrical figures live outside this logic.
  localparam int LISTEN_DELAY_US = 100;
  localparam int PERIOD_US = 100;
  localparam int RESP_DELAY_US = 16;
  localparam int RAMP_US = 16;
  localparam int HOLD_US = 16;
  localparam int LISTEN_DELAY_CYC = LISTEN_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int PERIOD_CYC = PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int RESP_DELAY_CYC = (RESP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CYC = RAMP_US * 1000 / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Addressing and commands
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_FIRST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'hf;
  localparam logic [3:0] CMD_REG_WRITE = 4'h1;
  localparam logic [7:0] REG_PHYS_ADDR = 8'h00;
  localparam logic [7:0] REG_SWITCH = 8'h01;
  localparam int TIMER_W = 24;

  typedef enum logic [2:0] {
    DSA_WAIT,
    DSA_LISTEN,
    DSA_DELAY,
    DSA_RAMP,
    DSA_HOLD,
    DSA_DONE
  } dsa_state_t;

endpackage

// ### design/dsa_sync.sv
`timescale 1ns/1ps
module dsa_sync
  import dsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule // dsa_sync

// ### design/dsa_addr.sv
// How it works
// - Signal-class slave only; no power-class logic.
// - Nonzero stored address wins; skip other methods.
// - Preprogrammed device keeps switch open until commanded.
// - Unaddressed device accepts global write setting address.
// - Once addressed, answer only own address.
// - Chain switch gate deactivated after power-up.
// - Listen after startup delay, each period onward.
// - After response delay, ramp toward double current.
// - Sense above unit: stop, count up, wait.
// - Sense low: finish ramp, then hold.
// - Quiet hold wins address one first round.
// - Later rounds win counter value instead.
// - Two request lines select single or double current.
// - Downstream sense comparison decides discovery winner.
// - After discovery, configure through own address.
// - Command taken only when address field matches.
`timescale 1ns/1ps
module dsa_addr
  import dsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] address_nvm_register,
  input wire logic disc_cmd_pulse,
  input wire logic cmd_valid,
  input wire logic [3:0] command_address_field,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_ext_data,
  input wire logic [7:0] cmd_reg_data,
  input wire logic sense_over_unit,
  output logic resp_single_req,
  output logic resp_double_req,
  output logic chain_switch_gate_output,
  output logic [3:0] phys_addr,
  output logic addr_valid,
  output logic cmd_accept,
  output logic discovery_active
);

  // ---------------------------------------------------------------------------
  // Pin input and decode
  // ---------------------------------------------------------------------------
  logic sense_s;
  dsa_sync u_sense (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .din(sense_over_unit),
    .dout(sense_s)
  );

  dsa_state_t st_q, st_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [TIMER_W-1:0] per_q;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] addr_q, addr_d;
  logic have_q, have_d;
  logic sw_q, sw_d;
  logic nvm_seen_q;

  // The address is whole after reset only once the strap has been sampled.
  wire nvm_prog = address_nvm_register != ADDR_GLOBAL;
  wire addr_match = have_q && (command_address_field == addr_q);
  wire global_hit = !have_q && (command_address_field == ADDR_GLOBAL);
  wire is_write = cmd_code == CMD_REG_WRITE;
  wire addr_write = cmd_valid && is_write && cmd_ext_data == REG_PHYS_ADDR
    && cmd_reg_data[3:0] != ADDR_GLOBAL && (addr_match || global_hit);
  wire sw_write = cmd_valid && is_write && addr_match
    && cmd_ext_data == REG_SWITCH;
  wire listen_ok = per_q == '0;
  wire tmr_done = tmr_q == '0;

  // ---------------------------------------------------------------------------
  // Discovery sequencer (signal-class only, no power-class paths)
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_done ? tmr_q : tmr_q - 1'b1;
    cnt_d = cnt_q;
    addr_d = addr_q;
    have_d = have_q;
    sw_d = sw_q;
    if (sw_write)
      sw_d = cmd_reg_data[0];
    case (st_q)
      DSA_WAIT:
        if (nvm_seen_q && tmr_done)
          st_d = have_q ? DSA_DONE : DSA_LISTEN;
      DSA_LISTEN:
        if (disc_cmd_pulse && listen_ok && !addr_write)
        begin
          st_d = DSA_DELAY;
          tmr_d = TIMER_W'(RESP_DELAY_CYC);
        end
      DSA_DELAY:
        if (tmr_done)
        begin
          st_d = DSA_RAMP;
          tmr_d = TIMER_W'(RAMP_CYC);
        end
      DSA_RAMP, DSA_HOLD:
        if (sense_s)
        begin
          st_d = DSA_LISTEN;
          if (cnt_q != ADDR_LAST)
            cnt_d = cnt_q + 1'b1;
        end
        else if (tmr_done && st_q == DSA_RAMP)
        begin
          st_d = DSA_HOLD;
          tmr_d = TIMER_W'(HOLD_CYC);
        end
        else if (tmr_done)
        begin
          addr_d = cnt_q;
          have_d = 1'b1;
          st_d = DSA_DONE;
        end
      DSA_DONE: ;
      default: st_d = DSA_WAIT;
    endcase
    // An address write wins over every step of discovery.
    // Placing it after the case keeps an addressed device from ramping again.
    // It also stops the startup wait from sending that device back to listening.
    if (addr_write)
    begin
      addr_d = cmd_reg_data[3:0];
      have_d = 1'b1;
      st_d = DSA_DONE;
    end
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= DSA_WAIT;
      tmr_q <= TIMER_W'(LISTEN_DELAY_CYC);
      cnt_q <= ADDR_FIRST;
      addr_q <= ADDR_GLOBAL;
      have_q <= 1'b0;
      sw_q <= 1'b0;
      nvm_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      sw_q <= sw_d;
      nvm_seen_q <= 1'b1;
      if (!nvm_seen_q && nvm_prog)
      begin
        addr_q <= address_nvm_register;
        have_q <= 1'b1;
      end
      else
      begin
        addr_q <= addr_d;
        have_q <= have_d;
      end
    end
  end

  // Listening window reopens PERIOD_CYC - RESP_DELAY_CYC cycles after each command taken in listen.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      per_q <= '0;
    else if (ce)
    begin
      if (st_q == DSA_LISTEN && disc_cmd_pulse && listen_ok)
        per_q <= TIMER_W'(PERIOD_CYC - RESP_DELAY_CYC);
      else if (!listen_ok)
        per_q <= per_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic single_q;
  logic double_q;
  logic acc_q;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      single_q <= 1'b0;
      double_q <= 1'b0;
      acc_q <= 1'b0;
    end
    else if (ce)
    begin
      // Ramp is analog; first half of ramp asks single, rest double.
      single_q <= st_d == DSA_RAMP && tmr_d > TIMER_W'(RAMP_CYC / 2);
      double_q <= (st_d == DSA_RAMP && tmr_d <= TIMER_W'(RAMP_CYC / 2))
        || st_d == DSA_HOLD;
      // Accept follows cmd_valid one cycle later, reporting what the address decode saw.
      acc_q <= cmd_valid && (addr_match || global_hit);
    end
  end

  assign resp_single_req = single_q;
  assign resp_double_req = double_q;
  assign chain_switch_gate_output = sw_q;
  assign phys_addr = addr_q;
  assign addr_valid = have_q;
  assign cmd_accept = acc_q;
  assign discovery_active = st_q != DSA_WAIT && st_q != DSA_DONE;

endmodule // dsa_addr

// ### dv/dsa_addr_chk.sv
`timescale 1ns/1ps
module dsa_addr_chk
  import dsa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [3:0] command_address_field,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_ext_data,
  input wire logic [7:0] cmd_reg_data,
  input wire logic sense_over_unit,
  input wire logic resp_single_req,
  input wire logic resp_double_req,
  input wire logic chain_switch_gate_output,
  input wire logic [3:0] phys_addr,
  input wire logic addr_valid,
  input wire logic cmd_accept
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic req;
  logic [16:0] cyc_q;
  assign req = resp_single_req | resp_double_req;
  // Saturates, so a long run cannot wrap back into the quiet window.
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) cyc_q <= 17'h0;
    else if (!(&cyc_q)) cyc_q <= cyc_q + 17'h1;
  sequence s_fight;
    req && sense_over_unit;
  endsequence
  sequence s_gwrite;
    cmd_valid && !addr_valid && command_address_field == ADDR_GLOBAL && cmd_code == CMD_REG_WRITE
      && cmd_ext_data == REG_PHYS_ADDR && cmd_reg_data[3:0] != 4'h0;
  endsequence
  a_req_late: assert property (req |-> int'(cyc_q) >= LISTEN_DELAY_CYC + RESP_DELAY_CYC - 8)
    else $error("request too early");
  a_ramp_order: assert property ($rose(resp_double_req) |-> $past(resp_single_req))
    else $error("double without single");
  // Two synchroniser stages and one output register lie between sense and the request.
  a_sense_stop: assert property (s_fight [*3] |=> !req)
    else $error("ramp not stopped");
  a_accept_cause: assert property (cmd_accept |-> $past(cmd_valid))
    else $error("accept without command");
  a_foreign_drop: assert property (cmd_valid && addr_valid && command_address_field != phys_addr
    |=> !cmd_accept)
    else $error("foreign command accepted");
  a_global_take: assert property (s_gwrite |=> addr_valid && phys_addr == $past(cmd_reg_data[3:0]))
    else $error("global write lost");
  a_switch_cause: assert property ($rose(chain_switch_gate_output)
    |-> $past(cmd_valid && cmd_ext_data == REG_SWITCH))
    else $error("switch closed uncommanded");
  a_addr_quiet: assert property (addr_valid |-> phys_addr != ADDR_GLOBAL && !req)
    else $error("bad address state");
endmodule // dsa_addr_chk

bind dsa_addr dsa_addr_chk chk (.*);

// ### dv/dsa_master_model.sv
`timescale 1ns/1ps
module dsa_master_model
  import dsa_pkg::*;
#(parameter int ROUNDS = 2)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sense_on,
  input wire logic resp_single_req,
  input wire logic resp_double_req,
  output logic disc_cmd_pulse,
  output logic sense_over_unit
);
  int cnt_q;
  int sent_q;
  // A downstream slave ramps in step with ours, so sense follows our request.
  assign sense_over_unit = sense_on & (resp_single_req | resp_double_req);
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      cnt_q <= 0;
      sent_q <= 0;
      disc_cmd_pulse <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 1;
      disc_cmd_pulse <= 1'b0;
      if (sent_q < ROUNDS && cnt_q == LISTEN_DELAY_CYC + 20 + sent_q * (PERIOD_CYC + 4))
      begin
        disc_cmd_pulse <= 1'b1;
        sent_q <= sent_q + 1;
      end
    end
endmodule // dsa_master_model

// ### dv/dsa_addr_tb.sv
`timescale 1ns/1ps
module dsa_addr_tb;
  import dsa_pkg::*;
  logic sys_clk, nrst, disc_cmd_pulse, cmd_valid, sense_over_unit, sense_on, discovery_active;
  logic resp_single_req, resp_double_req, chain_switch_gate_output, addr_valid, cmd_accept;
  logic [3:0] address_nvm_register, command_address_field, cmd_code, phys_addr;
  logic [7:0] cmd_ext_data, cmd_reg_data;
  int mismatches, n_tests, cyc;
  // Field, register, data, then expected accept, address and switch.
  logic [23:0] rows [6] = '{24'h305000, 24'h005150, 24'h007050, 24'h511151, 24'h411051,
    24'h510150};
  dsa_addr dut (.ce(1'b1), .*);
  dsa_master_model pm (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task stop_test();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task send(input logic [23:0] r);
    @(negedge sys_clk);
    command_address_field = r[23:20];
    cmd_ext_data = {4'h0, r[19:16]};
    cmd_reg_data = {4'h0, r[15:12]};
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk({3'h0, cmd_accept}, r[11:8]);
    chk(phys_addr, r[7:4]);
    chk({3'h0, chain_switch_gate_output}, r[3:0]);
  endtask
  task do_reset(input logic [3:0] nvm);
    address_nvm_register = nvm;
    nrst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({resp_single_req, resp_double_req, chain_switch_gate_output, addr_valid}, 4'h0);
    nrst = 1'b1;
    @(negedge sys_clk);
  endtask
  initial
  begin
    cmd_valid = 1'b0;
    command_address_field = 4'h0;
    cmd_code = CMD_REG_WRITE;
    cmd_ext_data = 8'h00;
    cmd_reg_data = 8'h00;
    sense_on = 1'b0;
    do_reset(4'h0);
    foreach (rows[i])
      send(rows[i]);
    $display("test commands done");
    do_reset(4'h0);
    wait (addr_valid === 1'b1);
    @(negedge sys_clk);
    chk(phys_addr, 4'h1);
    chk({resp_single_req, resp_double_req, discovery_active, 1'b0}, 4'h0);
    $display("test first round done");
    sense_on = 1'b1;
    do_reset(4'h0);
    wait (resp_single_req === 1'b1);
    wait (resp_single_req === 1'b0 && resp_double_req === 1'b0);
    @(negedge sys_clk);
    sense_on = 1'b0;
    chk({3'h0, addr_valid}, 4'h0);
    wait (addr_valid === 1'b1);
    @(negedge sys_clk);
    chk(phys_addr, 4'h2);
    chk({resp_single_req, resp_double_req, discovery_active, 1'b0}, 4'h0);
    send(24'h211121);
    $display("test discovery done");
    do_reset(4'h9);
    chk(phys_addr, 4'h9);
    send(24'h005090);
    send(24'h911191);
    $display("test stored address done");
    stop_test();
  end
endmodule // dsa_addr_tb
